// ### hw/dbs_mem.sv
// flip-flop storage with per-lane write strobes and a two-word read
module dbs_mem
    import dbs_pkg::*;
#(
    parameter int AW = DEF_ADDR_W,
    parameter int LANES = DEF_LANES
)
(
    // clock
    input wire logic ref_clk,
    // port side
    dbs_mem_if.mem mem_if
);
    localparam int DEPTH = 2**(AW+1);

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            // each lane is a nine-bit group with its own array,
            // so no array has more than one writing process
            logic [LANE_W-1:0] lane_q [DEPTH];
            always_ff @(posedge ref_clk)
            begin
                if (mem_if.wr_en && mem_if.wr_lane_en[g])
                begin
                    lane_q[mem_if.wr_idx] <=
                        mem_if.wr_data[g*LANE_W +: LANE_W];
                end
            end
            assign mem_if.rd_data0[g*LANE_W +: LANE_W] =
                lane_q[{mem_if.rd_idx, 1'b0}];
            assign mem_if.rd_data1[g*LANE_W +: LANE_W] =
                lane_q[{mem_if.rd_idx, 1'b1}];
        end
    endgenerate
endmodule

// ### hw/dbs_sram_port.sv
// double-rate two-word burst sram port with dll and echo clocks
// How it works
// - impedance updates only in non-output cycles
// - echo clock pair runs free with data
// - dll relocks after clock restart
// - missing input clock resets the dll
// - burst order follows burst start bit
// - read words at output edges t+1.5, t+2
// - stopped clock holds output words
// - pending bursts finish before clock stop
// - two lane enables for the narrow organisation
// - four lane enables for the wide organisation
// - lane enables used only inside writes
// - deselect after read finishes, then high-z
// - write words taken at next k, then k#
// - lanes map to nine-bit data groups
module dbs_sram_port
    import dbs_pkg::*;
#(
    parameter int LANES = DEF_LANES,
    parameter int AW = DEF_ADDR_W,
    parameter int STOP_CYC = STOP_DET_CYC,
    parameter int LOCK_CNT = LOCK_CYC
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // input and output timing clock pins
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic dll_off_n,
    // command and address pins
    input wire logic cycle_select_n,
    input wire logic read_not_write,
    input wire logic [AW-1:0] addr,
    input wire logic burst_start_bit,
    input wire logic byte_lane0_enable_n,
    input wire logic byte_lane1_enable_n,
    input wire logic byte_lane2_enable_n,
    input wire logic byte_lane3_enable_n,
    // common data bus
    input wire logic [LANES*LANE_W-1:0] dq_in,
    output logic [LANES*LANE_W-1:0] dq_out,
    output logic dq_oe,
    // echo clocks
    output logic echo_timing_pair,
    output logic echo_timing_pair_n,
    // impedance
    input wire logic [ZQ_W-1:0] impedance_code,
    output logic [ZQ_W-1:0] drive_code,
    // status
    output logic dll_locked,
    output logic clock_stopped
);
    localparam int DW = LANES * LANE_W;
    localparam int IN_W = 7 + AW + 1 + 4 + DW + ZQ_W;
    localparam int LCW = $clog2(LOCK_CNT + 1);
    localparam int ICW = $clog2(STOP_CYC + 1);

    dbs_mem_if #(.AW(AW), .LANES(LANES)) mem_if ();

    dbs_mem #(.AW(AW), .LANES(LANES)) u_mem
    (
        .ref_clk(ref_clk),
        .mem_if(mem_if)
    );

    // two-stage synchroniser on every pin except ref_clk and reset
    logic [IN_W-1:0] pin_s1_q;
    logic [IN_W-1:0] pin_s2_q;
    logic [3:0] clk_prev_q;
    logic k_s, kn_s, c_s, cn_s, doff_n_s, cs_n_s, rnw_s, bsb_s;
    logic [AW-1:0] addr_s;
    logic [3:0] lane_n_s;
    logic [DW-1:0] dq_s;
    logic [ZQ_W-1:0] zq_s;

    always_ff @(posedge ref_clk)
    begin
        pin_s1_q <= {k_clk, k_clk_n, c_clk, c_clk_n, dll_off_n,
                     cycle_select_n, read_not_write, addr, burst_start_bit,
                     byte_lane3_enable_n, byte_lane2_enable_n,
                     byte_lane1_enable_n, byte_lane0_enable_n,
                     dq_in, impedance_code};
        pin_s2_q <= pin_s1_q;
        clk_prev_q <= pin_s2_q[IN_W-1 -: 4];
    end

    assign {k_s, kn_s, c_s, cn_s, doff_n_s, cs_n_s, rnw_s, addr_s, bsb_s,
            lane_n_s, dq_s, zq_s} = pin_s2_q;

    logic k_rise, kn_rise, c_rise, cn_rise, out_p_rise, out_n_rise;
    assign k_rise = k_s & ~clk_prev_q[3];
    assign kn_rise = kn_s & ~clk_prev_q[2];
    assign c_rise = c_s & ~clk_prev_q[1];
    assign cn_rise = cn_s & ~clk_prev_q[0];

    // control state
    logic single_q, single_d, strap_done_q, strap_done_d;
    logic cmd_valid_q, cmd_valid_d, cmd_rd_q, cmd_rd_d;
    logic cmd_bsb_q, cmd_bsb_d;
    logic [AW-1:0] cmd_addr_q, cmd_addr_d;
    dbs_burst_t rd_phase_q, rd_phase_d, wr_phase_q, wr_phase_d;
    logic [DW-1:0] rd_w0_q, rd_w0_d, rd_w1_q, rd_w1_d;
    logic [DW-1:0] dq_out_q, dq_out_d;
    logic dq_oe_q, dq_oe_d;
    logic [AW-1:0] wr_addr_q, wr_addr_d;
    logic wr_bsb_q, wr_bsb_d;
    logic [ICW-1:0] idle_cnt_q, idle_cnt_d;
    logic clk_absent;
    dbs_dll_t dll_q, dll_d;
    logic [LCW-1:0] lock_cnt_q, lock_cnt_d;
    logic [ZQ_W-1:0] drive_code_q, drive_code_d;
    logic echo_q, echo_d, echo_n_q, echo_n_d;
    logic rd_start, wr_start, out_quiet;

    // single clock mode when both output clocks sit high
    assign out_p_rise = single_q ? k_rise : c_rise;
    assign out_n_rise = single_q ? kn_rise : cn_rise;
    assign rd_start = k_rise && cmd_valid_q && cmd_rd_q;
    assign wr_start = k_rise && cmd_valid_q && !cmd_rd_q;
    assign out_quiet = (rd_phase_q == B_IDLE) && !(cmd_valid_q && cmd_rd_q);
    assign clk_absent = (idle_cnt_q == ICW'(STOP_CYC));

    always_comb
    begin
        single_d = single_q;
        strap_done_d = strap_done_q;
        cmd_valid_d = cmd_valid_q;
        cmd_rd_d = cmd_rd_q;
        cmd_bsb_d = cmd_bsb_q;
        cmd_addr_d = cmd_addr_q;
        rd_phase_d = rd_phase_q;
        wr_phase_d = wr_phase_q;
        rd_w0_d = rd_w0_q;
        rd_w1_d = rd_w1_q;
        dq_out_d = dq_out_q;
        dq_oe_d = dq_oe_q;
        wr_addr_d = wr_addr_q;
        wr_bsb_d = wr_bsb_q;
        dll_d = dll_q;
        lock_cnt_d = lock_cnt_q;
        drive_code_d = drive_code_q;
        mem_if.wr_en = 1'b0;
        mem_if.wr_idx = {wr_addr_q, ~wr_bsb_q};
        mem_if.wr_data = dq_s;
        // lane enables only reach storage with wr_en set
        mem_if.wr_lane_en = ~lane_n_s[LANES-1:0];
        mem_if.rd_idx = cmd_addr_q;
        // strap caught once the synchroniser holds valid levels
        if (k_rise && !strap_done_q)
        begin
            strap_done_d = 1'b1;
            single_d = c_s & cn_s;
        end
        // with no edges only the dll below moves, so outputs hold
        if (out_n_rise && rd_phase_q == B_FIRST)
        begin
            dq_out_d = rd_w0_q;
            dq_oe_d = 1'b1;
            rd_phase_d = B_SECOND;
        end
        if (out_p_rise && rd_phase_q == B_SECOND)
        begin
            dq_out_d = rd_w1_q;
            rd_phase_d = B_IDLE;
        end
        if (kn_rise && wr_phase_q == B_SECOND)
        begin
            mem_if.wr_en = 1'b1;
            wr_phase_d = B_IDLE;
        end
        if (k_rise)
        begin
            cmd_valid_d = !cs_n_s;
            cmd_rd_d = rnw_s;
            cmd_addr_d = addr_s;
            cmd_bsb_d = bsb_s;
            if (out_quiet)
            begin
                dq_oe_d = 1'b0;
                // retune whenever no read is pending or in flight, writes included
                drive_code_d = zq_s;
            end
        end
        if (rd_start)
        begin
            rd_w0_d = cmd_bsb_q ? mem_if.rd_data1 : mem_if.rd_data0;
            rd_w1_d = cmd_bsb_q ? mem_if.rd_data0 : mem_if.rd_data1;
            rd_phase_d = B_FIRST;
        end
        if (wr_start)
        begin
            mem_if.wr_en = 1'b1;
            mem_if.wr_idx = {cmd_addr_q, cmd_bsb_q};
            wr_addr_d = cmd_addr_q;
            wr_bsb_d = cmd_bsb_q;
            wr_phase_d = B_SECOND;
        end
        // lock counted in input clock cycles after each enable or restart
        case (dll_q)
            DLL_OFF:
                if (doff_n_s && !clk_absent)
                begin
                    dll_d = DLL_LOCKING;
                    lock_cnt_d = '0;
                end
            DLL_LOCKING:
                if (k_rise)
                begin
                    lock_cnt_d = lock_cnt_q + LCW'(1);
                    if (lock_cnt_q == LCW'(LOCK_CNT - 1))
                        dll_d = DLL_LOCKED;
                end
            DLL_LOCKED: ;
            default: dll_d = DLL_OFF;
        endcase
        if (!doff_n_s || clk_absent)
        begin
            dll_d = DLL_OFF;
            lock_cnt_d = '0;
        end
    end

    always_comb
    begin
        if (k_rise || kn_rise)
            idle_cnt_d = '0;
        else if (clk_absent)
            idle_cnt_d = idle_cnt_q;
        else
            idle_cnt_d = idle_cnt_q + ICW'(1);
        echo_d = single_q ? k_s : c_s;
        echo_n_d = single_q ? kn_s : cn_s;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            single_q <= 1'b0;
            strap_done_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_rd_q <= 1'b0;
            cmd_bsb_q <= 1'b0;
            cmd_addr_q <= '0;
            rd_phase_q <= B_IDLE;
            wr_phase_q <= B_IDLE;
            rd_w0_q <= '0;
            rd_w1_q <= '0;
            dq_out_q <= '0;
            dq_oe_q <= 1'b0;
            wr_addr_q <= '0;
            wr_bsb_q <= 1'b0;
            idle_cnt_q <= '0;
            dll_q <= DLL_OFF;
            lock_cnt_q <= '0;
            drive_code_q <= DRIVE_RST;
            echo_q <= 1'b0;
            echo_n_q <= 1'b1;
        end
        else
        begin
            single_q <= single_d;
            strap_done_q <= strap_done_d;
            cmd_valid_q <= cmd_valid_d;
            cmd_rd_q <= cmd_rd_d;
            cmd_bsb_q <= cmd_bsb_d;
            cmd_addr_q <= cmd_addr_d;
            rd_phase_q <= rd_phase_d;
            wr_phase_q <= wr_phase_d;
            rd_w0_q <= rd_w0_d;
            rd_w1_q <= rd_w1_d;
            dq_out_q <= dq_out_d;
            dq_oe_q <= dq_oe_d;
            wr_addr_q <= wr_addr_d;
            wr_bsb_q <= wr_bsb_d;
            idle_cnt_q <= idle_cnt_d;
            dll_q <= dll_d;
            lock_cnt_q <= lock_cnt_d;
            drive_code_q <= drive_code_d;
            echo_q <= echo_d;
            echo_n_q <= echo_n_d;
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;
    assign echo_timing_pair = echo_q;
    assign echo_timing_pair_n = echo_n_q;
    assign drive_code = drive_code_q;
    assign dll_locked = (dll_q == DLL_LOCKED);
    // stop status waits for open bursts to drain
    assign clock_stopped = clk_absent && rd_phase_q == B_IDLE &&
                           wr_phase_q == B_IDLE;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_first_out;
        rd_phase_q == B_FIRST && out_n_rise;
    endsequence
    property p_first_word;
        s_first_out |=> dq_oe_q && dq_out_q == $past(rd_w0_q);
    endproperty
    a_first_word: assert property (p_first_word)
        else $error("first read word not driven");
    sequence s_second_out;
        rd_phase_q == B_SECOND && out_p_rise;
    endsequence
    property p_second_word;
        s_second_out |=> dq_out_q == $past(rd_w1_q, 1) && dq_oe_q;
    endproperty
    a_second_word: assert property (p_second_word)
        else $error("second read word not driven");
    property p_burst_order;
        rd_start |=> rd_w0_q == ($past(cmd_bsb_q) ? $past(mem_if.rd_data1)
                                 : $past(mem_if.rd_data0));
    endproperty
    a_burst_order: assert property (p_burst_order)
        else $error("burst order wrong");
    property p_hold_stopped;
        clk_absent && $past(clk_absent) |-> $stable(dq_out_q) &&
            $stable(dq_oe_q);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped)
        else $error("outputs moved while clock stopped");
    property p_dll_reset;
        clk_absent |=> dll_q == DLL_OFF && lock_cnt_q == '0;
    endproperty
    a_dll_reset: assert property (p_dll_reset)
        else $error("dll not reset on missing clock");
    property p_lock_count;
        $rose(dll_q == DLL_LOCKED) |-> lock_cnt_q == LCW'(LOCK_CNT);
    endproperty
    a_lock_count: assert property (p_lock_count)
        else $error("dll locked early");
    property p_write_window;
        mem_if.wr_en |-> wr_start || (kn_rise && wr_phase_q == B_SECOND);
    endproperty
    a_write_window: assert property (p_write_window)
        else $error("write outside a write burst");
    property p_write_beat;
        wr_start |-> mem_if.wr_en && mem_if.wr_data == dq_s &&
            mem_if.wr_lane_en == ~lane_n_s[LANES-1:0];
    endproperty
    a_write_beat: assert property (p_write_beat)
        else $error("first write beat not stored");
    property p_zq_quiet;
        $changed(drive_code_q) |-> $past(rd_phase_q) == B_IDLE &&
            !$past(cmd_valid_q && cmd_rd_q);
    endproperty
    a_zq_quiet: assert property (p_zq_quiet)
        else $error("impedance changed during a read");
    property p_deselect;
        k_rise && out_quiet |=> !dq_oe_q;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("outputs not released on deselect");
    property p_stop_drained;
        clock_stopped |-> wr_phase_q == B_IDLE && !mem_if.wr_en;
    endproperty
    a_stop_drained: assert property (p_stop_drained)
        else $error("clock stop with open burst");
endmodule

// ### pkg/dbs_mem_if.sv
// write and paired read port between the port logic and the storage
interface dbs_mem_if #(parameter int AW = 18, parameter int LANES = 4);
    localparam int DW = LANES * 9;
    logic wr_en;
    logic [AW:0] wr_idx;
    logic [DW-1:0] wr_data;
    logic [LANES-1:0] wr_lane_en;
    logic [AW-1:0] rd_idx;
    logic [DW-1:0] rd_data0;
    logic [DW-1:0] rd_data1;
    modport ctrl (output wr_en, wr_idx, wr_data, wr_lane_en, rd_idx,
                  input rd_data0, rd_data1);
    modport mem (input wr_en, wr_idx, wr_data, wr_lane_en, rd_idx,
                 output rd_data0, rd_data1);
endinterface

// ### pkg/dbs_pkg.sv
// constants and types shared by the burst sram port and its storage
package dbs_pkg;
    localparam int LANE_W = 9;
    localparam int DEF_LANES = 4;
    localparam int DEF_ADDR_W = 18;
    localparam int ZQ_W = 6;
    localparam logic [ZQ_W-1:0] DRIVE_RST = 6'h20;
    // dll lock, counted in input clock cycles
    localparam int LOCK_CYC = 1024;
    localparam int CLK_PERIOD_NS = 50;
    localparam int KSTATIC_NS = 30;
    localparam int KSTATIC_CYC_RAW =
        (KSTATIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int KSTATIC_CYC = (KSTATIC_CYC_RAW < 1) ? 1 : KSTATIC_CYC_RAW;
    // absence detector must outlast the slowest legal input clock period
    localparam int STOP_DET_CYC = (KSTATIC_CYC > 16) ? KSTATIC_CYC : 16;

    typedef enum logic [1:0] {B_IDLE, B_FIRST, B_SECOND} dbs_burst_t;
    typedef enum logic [1:0] {DLL_OFF, DLL_LOCKING, DLL_LOCKED} dbs_dll_t;
endpackage

// ### verification/dbs_ctrl_model.sv
// memory controller model: timing clocks, commands and write beats
module dbs_ctrl_model
    import dbs_pkg::*;
#(
    parameter int AW = 4
)
(
    // clock
    input wire logic ref_clk,
    // pins toward the port
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    output logic dll_off_n,
    output logic cycle_select_n,
    output logic read_not_write,
    output logic [AW-1:0] addr,
    output logic burst_start_bit,
    output logic [3:0] lane_n,
    output logic [35:0] dq_in,
    // samples from the port
    input wire logic [35:0] dq_out,
    input wire logic dq_oe,
    input wire logic echo_p,
    input wire logic echo_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // single clock mode: output clock pins parked high
    logic single = 1'b0;

    initial
    begin
        {k_clk, k_clk_n, c_clk, c_clk_n} = 4'h5;
        dll_off_n = 1'b0;
        {cycle_select_n, read_not_write, addr, burst_start_bit} = '1;
        lane_n = 4'hf;
        dq_in = 36'h0;
    end

    // one k period of eight ref cycles; edges four cycles apart
    task automatic slot(input logic [AW+2:0] cmd, input logic [35:0] d0,
        input logic [35:0] d1, input logic [3:0] be_n,
        output logic [35:0] qa, output logic [35:0] qb,
        output logic [2:0] sa, output logic [2:0] sb);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge ref_clk);
            case (i)
                0:
                begin
                    {cycle_select_n, read_not_write, addr,
                        burst_start_bit} = cmd;
                    dq_in = d0;
                    lane_n = be_n;
                end
                1: {k_clk, k_clk_n, c_clk, c_clk_n} =
                    single ? 4'hb : 4'ha;
                3:
                begin
                    qa = dq_out;
                    sa = {dq_oe, echo_p, echo_n};
                    dq_in = d1;
                end
                5: {k_clk, k_clk_n, c_clk, c_clk_n} = single ? 4'h7 : 4'h5;
                7:
                begin
                    qb = dq_out;
                    sb = {dq_oe, echo_p, echo_n};
                end
                default: ;
            endcase
        end
    endtask

    // deselect cycles; data toggles so stale values never look valid
    task automatic idle(input int n);
        logic [35:0] qa;
        logic [35:0] qb;
        logic [2:0] sa;
        logic [2:0] sb;
        repeat (n)
            slot('1, ~dq_in, dq_in, 4'h0, qa, qb, sa, sb);
    endtask

    task automatic enable();
        dll_off_n = 1'b1;
    endtask
endmodule

// ### verification/testbench.sv
// self-checking bench for the burst sram port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 4;
    localparam int LOCK_N = 8;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic k_clk, k_clk_n, c_clk, c_clk_n, dll_off_n, sel_n, rnw, bsb;
    logic [AW-1:0] addr;
    logic [3:0] lane_n;
    logic [35:0] dq_in, dq_out;
    logic dq_oe, echo, echo_n, dll_locked, clock_stopped;
    logic [5:0] zq_in = 6'h15;
    logic [5:0] drive_code;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [35:0] ref_mem [0:31];
    logic [35:0] ex0, ex1;
    logic [3:0] rd_h = 4'h0;
    logic pw = 1'b0;
    logic [AW:0] cur_i = '0;
    logic [3:0] pw_be = 4'h0;
    logic [8:0] seq = 9'h0;

    always #25 ref_clk = ~ref_clk;

    dbs_sram_port #(.LANES(4), .AW(AW), .LOCK_CNT(LOCK_N)) dut_u (
        .ref_clk(ref_clk), .reset(reset), .k_clk(k_clk),
        .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n),
        .dll_off_n(dll_off_n), .cycle_select_n(sel_n),
        .read_not_write(rnw), .addr(addr), .burst_start_bit(bsb),
        .byte_lane0_enable_n(lane_n[0]), .byte_lane1_enable_n(lane_n[1]),
        .byte_lane2_enable_n(lane_n[2]), .byte_lane3_enable_n(lane_n[3]),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .echo_timing_pair(echo), .echo_timing_pair_n(echo_n),
        .impedance_code(zq_in), .drive_code(drive_code),
        .dll_locked(dll_locked), .clock_stopped(clock_stopped));

    dbs_ctrl_model #(.AW(AW)) ctl_u (
        .ref_clk(ref_clk), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .c_clk(c_clk), .c_clk_n(c_clk_n), .dll_off_n(dll_off_n),
        .cycle_select_n(sel_n), .read_not_write(rnw), .addr(addr),
        .burst_start_bit(bsb), .lane_n(lane_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .echo_p(echo), .echo_n(echo_n));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            $display("ERROR timeout expected done seen running");
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [35:0] e,
        input logic [35:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n,
        logic [3:0] be);
        for (int g = 0; g < 4; g++)
            if (!be[g])
                o[9*g +: 9] = n[9*g +: 9];
        return o;
    endfunction

    // one slot: write beats of the last command, checks of the one before
    task automatic step(input logic sn, input logic rw,
        input logic [AW-1:0] a, input logic b, input logic [3:0] be);
        logic [35:0] d0, d1, x0, x1, qa, qb;
        logic [2:0] sa, sb;
        seq = seq + 9'h01b;
        d0 = {seq, ~seq, seq ^ 9'h0a5, seq + 9'h033};
        d1 = {d0[17:0], d0[35:18]} ^ 36'h5a5a5a5a5;
        // storage is read at this k rise, before this slot's write lands
        x0 = ref_mem[cur_i];
        x1 = ref_mem[cur_i ^ 1'b1];
        if (pw)
        begin
            ref_mem[cur_i] = merge(ref_mem[cur_i], d0, pw_be);
            ref_mem[cur_i ^ 1'b1] = merge(ref_mem[cur_i ^ 1'b1], d1, pw_be);
        end
        ctl_u.slot({sn, rw, a, b}, d0, d1, pw ? pw_be : 4'h0,
            qa, qb, sa, sb);
        if (rd_h[1])
        begin
            chk("first word", ex0, qa);
            chk("second word", ex1, qb);
            chk("drive on", 1'b1, sa[2]);
        end
        if (rd_h[3:1] == 3'b000)
            chk("drive off", 1'b0, sa[2]);
        chk("echo", 4'h6, {sa[1:0], sb[1:0]});
        ex0 = x0;
        ex1 = x1;
        cur_i = {a, b};
        rd_h = {rd_h[2:0], !sn && rw};
        pw = !sn && !rw;
        pw_be = be;
    endtask

    task automatic drain();
        repeat (4) step(1'b1, 1'b0, 4'h0, 1'b0, 4'h0);
    endtask

    task automatic t_lock();
        ctl_u.idle(4);
        chk("locked", 1'b0, dll_locked);
        ctl_u.enable();
        ctl_u.idle(LOCK_N - 4);
        chk("locked", 1'b0, dll_locked);
        ctl_u.idle(8);
        chk("locked", 1'b1, dll_locked);
    endtask

    task automatic t_wr_rd();
        logic [3:0] ln [7] = '{4'h0, 4'he, 4'hd, 4'h3, 4'hf, 4'hb, 4'h7};
        for (int i = 0; i < 8; i++)
            step(1'b0, 1'b0, i[3:0], i[0], 4'h0);
        for (int i = 0; i < 16; i++)
            step(1'b0, 1'b1, {1'b0, i[3:1]}, i[0], 4'h0);
        foreach (ln[k])
            step(1'b0, 1'b0, k[3:0], 1'b1, ln[k]);
        step(1'b1, 1'b0, 4'h0, 1'b0, 4'h0);
        foreach (ln[k])
            step(1'b0, 1'b1, k[3:0], k[0], 4'h0);
        step(1'b0, 1'b1, 4'h2, 1'b0, 4'h0);
        step(1'b0, 1'b0, 4'h2, 1'b0, 4'h6);
        step(1'b0, 1'b1, 4'h2, 1'b1, 4'h0);
        drain();
    endtask

    task automatic t_zq();
        drain();
        chk("drive code", 6'h15, drive_code);
        step(1'b0, 1'b1, 4'h1, 1'b0, 4'h0);
        zq_in = 6'h2a;
        repeat (3) step(1'b0, 1'b1, 4'h1, 1'b1, 4'h0);
        chk("drive held", 6'h15, drive_code);
        drain();
        chk("drive code", 6'h2a, drive_code);
    endtask

    task automatic t_stop();
        logic [35:0] q;
        step(1'b0, 1'b0, 4'h9, 1'b0, 4'h0);
        step(1'b0, 1'b1, 4'h3, 1'b1, 4'h0);
        drain();
        q = dq_out;
        // pins stay put, longer than the absence detector's window
        repeat (24) @(negedge ref_clk);
        chk("locked", 1'b0, dll_locked);
        chk("stopped", 1'b1, clock_stopped);
        chk("held", q, dq_out);
        ctl_u.idle(LOCK_N + 4);
        chk("locked", 1'b1, dll_locked);
        chk("stopped", 1'b0, clock_stopped);
        step(1'b0, 1'b1, 4'h9, 1'b0, 4'h0);
        drain();
    endtask

    // second reset with output clocks parked high: single clock strap
    task automatic t_single();
        @(negedge ref_clk);
        reset = 1'b1;
        ctl_u.single = 1'b1;
        {ctl_u.c_clk, ctl_u.c_clk_n} = 2'b11;
        repeat (4) @(negedge ref_clk);
        reset = 1'b0;
        chk("drive off", 1'b0, dq_oe);
        chk("locked", 1'b0, dll_locked);
        ctl_u.idle(LOCK_N + 4);
        chk("locked", 1'b1, dll_locked);
        step(1'b0, 1'b0, 4'h5, 1'b1, 4'h0);
        step(1'b0, 1'b1, 4'h5, 1'b1, 4'h0);
        step(1'b0, 1'b1, 4'h9, 1'b0, 4'h0);
        drain();
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        chk("drive code", 6'h20, drive_code);
        chk("drive off", 1'b0, dq_oe);
        t_lock();
        t_wr_rd();
        t_zq();
        t_stop();
        t_single();
        end_sim();
    end
endmodule
